// [src/quh_chan.sv]
// one channel: register set, transmit and receive fifos, interrupt condition
`include "quh_regs.svh"
`default_nettype none
module quh_chan
    import quh_pkg::*;
#(
    parameter int DEPTH = `QUH_FIFO_DEPTH,
    parameter int TX_TRIG = `QUH_TX_TRIG
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host access, one-cycle pulses
    input wire logic wr_en,
    input wire logic rd_en,
    input wire quh_reg_addr_t addr,
    input wire quh_byte_t wdata,
    output quh_byte_t rdata,
    // serial side stand-ins
    input wire logic rx_push,
    input wire quh_byte_t rx_byte,
    input wire logic tx_pop,
    output quh_byte_t tx_head,
    output logic tx_empty,
    // interrupt
    output logic irq,
    output logic irq_gate
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    quh_byte_t tx_mem [DEPTH];
    quh_byte_t rx_mem [DEPTH];
    logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic [CW-1:0] tx_cnt_r, rx_cnt_r, cap, rx_trig;
    quh_byte_t ier_r, fcr_r, lcr_r, mcr_r, dll_r, dlm_r, spr_r, irq_status;
    logic overrun_r;
    logic div_acc, fcr_wr, tx_clr, rx_clr, tx_push, tx_do_pop, rx_do_push, rx_do_pop;
    logic rx_cond, tx_cond;

    assign div_acc = lcr_r[`QUH_LCR_DIV_ACCESS];
    // fifo disabled behaves as a single holding byte
    assign cap = fcr_r[`QUH_FCR_FIFO_EN] ? CW'(DEPTH) : CW'(1);
    assign fcr_wr = wr_en && addr == `QUH_REG_ISR;
    // toggling fifo enable flushes both fifos so counts never exceed cap
    assign tx_clr = fcr_wr && (wdata[`QUH_FCR_TX_CLR]
                    || wdata[`QUH_FCR_FIFO_EN] != fcr_r[`QUH_FCR_FIFO_EN]);
    assign rx_clr = fcr_wr && (wdata[`QUH_FCR_RX_CLR]
                    || wdata[`QUH_FCR_FIFO_EN] != fcr_r[`QUH_FCR_FIFO_EN]);
    assign tx_push = wr_en && addr == `QUH_REG_DATA && !div_acc && tx_cnt_r < cap;
    assign tx_do_pop = tx_pop && tx_cnt_r != '0;
    assign rx_do_push = rx_push && rx_cnt_r < cap;
    assign rx_do_pop = rd_en && addr == `QUH_REG_DATA && !div_acc && rx_cnt_r != '0;
    assign tx_head = tx_mem[tx_rp_r];
    assign tx_empty = tx_cnt_r == '0;
    assign irq_gate = mcr_r[`QUH_MCR_IRQ_GATE];

    // each channel keeps its own register set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ier_r <= 8'h00;
            fcr_r <= 8'h00;
            lcr_r <= 8'h00;
            mcr_r <= 8'h00;
            dll_r <= `QUH_DIV_LOW_RST;
            dlm_r <= `QUH_DIV_HIGH_RST;
            spr_r <= 8'h00;
        end
        else if (wr_en)
        begin
            if (addr == `QUH_REG_DATA && div_acc)
                dll_r <= wdata;
            else if (addr == `QUH_REG_IER && div_acc)
                dlm_r <= wdata;
            else if (addr == `QUH_REG_IER)
                ier_r <= {4'h0, wdata[3:0]};
            else if (addr == `QUH_REG_ISR)
                fcr_r <= {wdata[7:6], 2'b00, wdata[3], 2'b00, wdata[0]};
            else if (addr == `QUH_REG_LCR)
                lcr_r <= wdata;
            else if (addr == `QUH_REG_MCR)
                mcr_r <= wdata;
            else if (addr == `QUH_REG_SPR)
                spr_r <= wdata;
        end
    end

    // 16-byte transmit fifo
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_cnt_r <= '0;
        end
        else if (tx_clr)
        begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_cnt_r <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp_r <= tx_wp_r + AW'(1);
            if (tx_do_pop)
                tx_rp_r <= tx_rp_r + AW'(1);
            if (tx_push && !tx_do_pop)
                tx_cnt_r <= tx_cnt_r + CW'(1);
            else if (!tx_push && tx_do_pop)
                tx_cnt_r <= tx_cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (tx_push && !tx_clr)
            tx_mem[tx_wp_r] <= wdata;
        if (rx_do_push && !rx_clr)
            rx_mem[rx_wp_r] <= rx_byte;
    end

    // 16-byte receive fifo
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_cnt_r <= '0;
        end
        else if (rx_clr)
        begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_cnt_r <= '0;
        end
        else
        begin
            if (rx_do_push)
                rx_wp_r <= rx_wp_r + AW'(1);
            if (rx_do_pop)
                rx_rp_r <= rx_rp_r + AW'(1);
            if (rx_do_push && !rx_do_pop)
                rx_cnt_r <= rx_cnt_r + CW'(1);
            else if (!rx_do_push && rx_do_pop)
                rx_cnt_r <= rx_cnt_r - CW'(1);
        end
    end

    // overrun: a lost byte in the same cycle as the status read still sets
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overrun_r <= 1'b0;
        else if (rx_push && !rx_do_push)
            overrun_r <= 1'b1;
        else if (rd_en && addr == `QUH_REG_LSR)
            overrun_r <= 1'b0;
    end

    // selectable receive trigger level
    always_comb
    begin
        case (fcr_r[7:6])
            2'b00: rx_trig = CW'(`QUH_RX_TRIG0);
            2'b01: rx_trig = CW'(`QUH_RX_TRIG1);
            2'b10: rx_trig = CW'(`QUH_RX_TRIG2);
            default: rx_trig = CW'(`QUH_RX_TRIG3);
        endcase
    end

    // receive condition: one byte, or trigger reached with fifos on
    assign rx_cond = fcr_r[`QUH_FCR_FIFO_EN] ? (rx_cnt_r >= rx_trig) : (rx_cnt_r != '0);
    // transmit condition: holding empty, or below trigger in block mode
    assign tx_cond = (fcr_r[`QUH_FCR_FIFO_EN] && fcr_r[`QUH_FCR_BLOCK])
                     ? (tx_cnt_r < CW'(TX_TRIG)) : (tx_cnt_r == '0);
    assign irq = (ier_r[`QUH_IER_RX] && rx_cond) || (ier_r[`QUH_IER_TX] && tx_cond);

    always_comb
    begin
        if (ier_r[`QUH_IER_RX] && rx_cond)
            irq_status = `QUH_ISR_RX;
        else if (ier_r[`QUH_IER_TX] && tx_cond)
            irq_status = `QUH_ISR_TX;
        else
            irq_status = `QUH_ISR_NONE;
        if (fcr_r[`QUH_FCR_FIFO_EN])
            irq_status = irq_status | `QUH_ISR_FIFO_FLAGS;
    end

    always_comb
    begin
        rdata = 8'h00;
        if (addr == `QUH_REG_DATA)
            rdata = div_acc ? dll_r : rx_mem[rx_rp_r];
        else if (addr == `QUH_REG_IER)
            rdata = div_acc ? dlm_r : ier_r;
        else if (addr == `QUH_REG_ISR)
            rdata = irq_status;
        else if (addr == `QUH_REG_LCR)
            rdata = lcr_r;
        else if (addr == `QUH_REG_MCR)
            rdata = mcr_r;
        else if (addr == `QUH_REG_LSR)
        begin
            rdata[`QUH_LSR_DATA_READY] = rx_cnt_r != '0;
            rdata[`QUH_LSR_OVERRUN] = overrun_r;
            rdata[`QUH_LSR_TX_SPACE] = tx_cnt_r < cap;
            rdata[`QUH_LSR_TX_EMPTY] = tx_cnt_r == '0;
        end
        else if (addr == `QUH_REG_SPR)
            rdata = spr_r;
    end
endmodule
`default_nettype wire

// [src/quh_pkg.sv]
// shared types for the quad host port
`default_nettype none
package quh_pkg;
    typedef logic [7:0] quh_byte_t;
    typedef logic [2:0] quh_reg_addr_t;
    typedef logic [1:0] quh_chan_t;
    typedef enum logic {QUH_STYLE_DIRECTION, QUH_STYLE_STROBE} quh_style_t;
endpackage
`default_nettype wire

// [src/quh_regs.svh]
// register offsets, field positions, reset values and timing counts for the quad host port
`ifndef QUH_REGS_SVH
`define QUH_REGS_SVH

`define QUH_REG_DATA 3'h0
`define QUH_REG_IER 3'h1
`define QUH_REG_ISR 3'h2
`define QUH_REG_LCR 3'h3
`define QUH_REG_MCR 3'h4
`define QUH_REG_LSR 3'h5
`define QUH_REG_MSR 3'h6
`define QUH_REG_SPR 3'h7

`define QUH_IER_RX 0
`define QUH_IER_TX 1
`define QUH_FCR_FIFO_EN 0
`define QUH_FCR_RX_CLR 1
`define QUH_FCR_TX_CLR 2
`define QUH_FCR_BLOCK 3
`define QUH_LCR_DIV_ACCESS 7
`define QUH_MCR_IRQ_GATE 3
`define QUH_LSR_DATA_READY 0
`define QUH_LSR_OVERRUN 1
`define QUH_LSR_TX_SPACE 5
`define QUH_LSR_TX_EMPTY 6

`define QUH_DIV_LOW_RST 8'h01
`define QUH_DIV_HIGH_RST 8'h00
`define QUH_ISR_NONE 8'h01
`define QUH_ISR_RX 8'h04
`define QUH_ISR_TX 8'h02
`define QUH_ISR_FIFO_FLAGS 8'hC0

`define QUH_FIFO_DEPTH 16
`define QUH_TX_TRIG 8
`define QUH_RX_TRIG0 1
`define QUH_RX_TRIG1 4
`define QUH_RX_TRIG2 8
`define QUH_RX_TRIG3 14

`define QUH_CLK_PERIOD_NS 10
`define QUH_RESET_MIN_NS 40
`define QUH_RESET_MIN_CYC ((`QUH_RESET_MIN_NS + `QUH_CLK_PERIOD_NS - 1) / `QUH_CLK_PERIOD_NS)

`endif

// [src/quh_top.sv]
// quad channel host port: bus style, channel select, broadcast write, interrupt pins
`include "quh_regs.svh"
`default_nettype none
module quh_top
    import quh_pkg::*;
#(
    parameter int DEPTH = `QUH_FIFO_DEPTH,
    parameter int TX_TRIG = `QUH_TX_TRIG
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // bus style strap
    input wire logic BUS_STYLE_STROBE,
    // strobe style controls
    input wire logic CHAN_A_SELECT_N,
    input wire logic CHAN_B_SELECT_N,
    input wire logic CHAN_C_SELECT_N,
    input wire logic CHAN_D_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    // direction style controls
    input wire logic CHIP_SELECT_N,
    input wire logic READ_NOT_WRITE,
    input wire logic CHAN_ADDR_LOW,
    input wire logic CHAN_ADDR_HIGH,
    // shared register address and data
    input wire quh_reg_addr_t REG_ADDR,
    input wire quh_byte_t DATA_IN,
    output quh_byte_t DATA_OUT,
    output logic DATA_OE,
    // interrupts
    input wire logic IRQ_STYLE_SELECT,
    output logic [3:0] CHAN_IRQ,
    output logic [3:0] CHAN_IRQ_OE,
    // serial side stand-ins
    output logic [3:0] SERIAL_TX,
    input wire logic [3:0] RX_PUSH,
    input wire logic [31:0] RX_BYTE,
    input wire logic [3:0] TX_POP,
    output logic [31:0] TX_BYTE,
    output logic [3:0] TX_VALID
);
    quh_style_t style;
    logic [3:0] sel, wr_sel, rd_sel, ch_irq, ch_gate, ch_empty;
    logic rd_now, wr_now, rd_prev_r, wr_prev_r, rd_start, wr_start;
    quh_byte_t ch_rdata [4];
    quh_byte_t ch_head [4];
    quh_byte_t rd_mux;

    // strap high is strobe style
    assign style = BUS_STYLE_STROBE ? QUH_STYLE_STROBE : QUH_STYLE_DIRECTION;

    // channel decode from select and address inputs only
    always_comb
    begin
        sel = 4'h0;
        if (style == QUH_STYLE_STROBE)
            sel = ~{CHAN_D_SELECT_N, CHAN_C_SELECT_N, CHAN_B_SELECT_N, CHAN_A_SELECT_N};
        else if (!CHIP_SELECT_N)
            sel[{CHAN_ADDR_HIGH, CHAN_ADDR_LOW}] = 1'b1;
    end

    // strobes count only while some channel is selected
    assign rd_now = (style == QUH_STYLE_STROBE) ? (!READ_STROBE_N && sel != 4'h0)
                    : (!CHIP_SELECT_N && READ_NOT_WRITE);
    assign wr_now = (style == QUH_STYLE_STROBE) ? (!WRITE_STROBE_N && sel != 4'h0)
                    : (!CHIP_SELECT_N && !READ_NOT_WRITE);
    assign rd_start = rd_now && !rd_prev_r;
    // write data taken on the leading edge of the strobe
    assign wr_start = wr_now && !wr_prev_r;

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end
        else
        begin
            rd_prev_r <= rd_now;
            wr_prev_r <= wr_now;
        end
    end

    // every selected channel takes the write, so all four low broadcasts
    assign wr_sel = wr_start ? sel : 4'h0;

    // a multi-select read is the host's fault; lowest channel answers so fifos pop once
    always_comb
    begin
        rd_sel = 4'h0;
        rd_mux = 8'h00;
        if (sel[0])
        begin
            rd_sel[0] = rd_start;
            rd_mux = ch_rdata[0];
        end
        else if (sel[1])
        begin
            rd_sel[1] = rd_start;
            rd_mux = ch_rdata[1];
        end
        else if (sel[2])
        begin
            rd_sel[2] = rd_start;
            rd_mux = ch_rdata[2];
        end
        else if (sel[3])
        begin
            rd_sel[3] = rd_start;
            rd_mux = ch_rdata[3];
        end
    end

    // one shared data bus for all channels
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
        end
        else
        begin
            if (rd_start)
                DATA_OUT <= rd_mux;
            DATA_OE <= rd_now;
        end
    end

    // independent channels
    for (genvar i = 0; i < 4; i++)
    begin : g_chan
        quh_chan #(
            .DEPTH(DEPTH),
            .TX_TRIG(TX_TRIG)
        ) u_chan (
            .clk(CLOCK),
            .rst_n(RESETN),
            .wr_en(wr_sel[i]),
            .rd_en(rd_sel[i]),
            .addr(REG_ADDR),
            .wdata(DATA_IN),
            .rdata(ch_rdata[i]),
            .rx_push(RX_PUSH[i]),
            .rx_byte(RX_BYTE[8*i +: 8]),
            .tx_pop(TX_POP[i]),
            .tx_head(ch_head[i]),
            .tx_empty(ch_empty[i]),
            .irq(ch_irq[i]),
            .irq_gate(ch_gate[i])
        );
    end

    // one process owns the whole word, so no output is split across processes
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            TX_BYTE <= 32'h00000000;
            TX_VALID <= 4'h0;
        end
        else
        begin
            TX_BYTE <= {ch_head[3], ch_head[2], ch_head[1], ch_head[0]};
            TX_VALID <= ~ch_empty;
        end
    end

    // pins follow channel conditions one cycle late
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CHAN_IRQ <= 4'h0;
            CHAN_IRQ_OE <= 4'h0;
        end
        else
        begin
            CHAN_IRQ <= ch_irq;
            // gated drive only in strobe style with style input low
            if (style == QUH_STYLE_STROBE && !IRQ_STYLE_SELECT)
                CHAN_IRQ_OE <= ch_gate;
            else
                CHAN_IRQ_OE <= 4'hF;
        end
    end

    // no shifter here: line idles high, and held high through reset
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            SERIAL_TX <= 4'hF;
        else
            SERIAL_TX <= 4'hF;
    end
endmodule
`default_nettype wire

// [testbench/quh_host_model.sv]
// host processor model driving either bus style of the quad host port
`default_nettype none
module quh_host_model
    import quh_pkg::*;
(
    // clock and strap
    input wire logic clk,
    input wire logic strobe_style,
    // strobe style
    output logic [3:0] sel_n,
    output logic rd_n,
    output logic wr_n,
    // direction style
    output logic cs_n,
    output logic rnw,
    output logic [1:0] chan_addr,
    // shared
    output quh_reg_addr_t addr,
    output quh_byte_t din,
    input wire quh_byte_t dout
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sel_n = 4'hF;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        rnw = 1'b1;
        chan_addr = 2'h0;
        addr = 3'h0;
        din = 8'h00;
    end
    // c is a channel number, or 4 for all channels in strobe style (channel 0 in direction style); held two edges, a held strobe
    // must not repeat the access
    task automatic acc(input logic w, input int c, input quh_reg_addr_t a,
            input quh_byte_t d, output quh_byte_t q);
        @(posedge clk);
        #1;
        addr = a;
        din = d;
        // deliberately wrong in strobe style, where these lines must not matter
        chan_addr = strobe_style ? ~c[1:0] : c[1:0];
        if (strobe_style)
        begin
            sel_n = (c == 4) ? 4'h0 : ~(4'h1 << c);
            rd_n = w;
            wr_n = !w;
        end
        else
        begin
            cs_n = 1'b0;
            rnw = !w;
        end
        repeat (2) @(posedge clk);
        q = dout;
        #1;
        sel_n = 4'hF;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        // released lines must not keep showing the last value
        addr = ~a;
        din = ~d;
    endtask
endmodule
`default_nettype wire

// [testbench/quh_top_chk.sv]
// pin-level properties of the quad host port
`default_nettype none
module quh_top_chk
    import quh_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // host bus
    input wire logic BUS_STYLE_STROBE,
    input wire logic CHAN_A_SELECT_N,
    input wire logic CHAN_B_SELECT_N,
    input wire logic CHAN_C_SELECT_N,
    input wire logic CHAN_D_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_NOT_WRITE,
    input wire logic CHAN_ADDR_LOW,
    input wire logic CHAN_ADDR_HIGH,
    input wire quh_reg_addr_t REG_ADDR,
    input wire quh_byte_t DATA_OUT,
    input wire logic DATA_OE,
    // interrupts and serial side
    input wire logic IRQ_STYLE_SELECT,
    input wire logic [3:0] CHAN_IRQ,
    input wire logic [3:0] CHAN_IRQ_OE,
    input wire logic [3:0] SERIAL_TX,
    input wire logic [3:0] TX_POP,
    input wire logic [31:0] TX_BYTE,
    input wire logic [3:0] TX_VALID
);
    timeunit 1ns;
    timeprecision 100ps;
    logic any_sel;
    logic rd;
    logic wr_c;
    logic dir_c;
    assign any_sel = !(CHAN_A_SELECT_N && CHAN_B_SELECT_N && CHAN_C_SELECT_N && CHAN_D_SELECT_N);
    assign rd = BUS_STYLE_STROBE ? (!READ_STROBE_N && any_sel)
        : (!CHIP_SELECT_N && READ_NOT_WRITE);
    assign dir_c = !CHIP_SELECT_N && !READ_NOT_WRITE && CHAN_ADDR_HIGH && !CHAN_ADDR_LOW;
    // channel c holding write, either bus style; channel c is the one the bench fills
    assign wr_c = (REG_ADDR == 3'h0)
        && (BUS_STYLE_STROBE ? (!WRITE_STROBE_N && !CHAN_C_SELECT_N) : dir_c);

    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    a_serial_tx_idle: assert property (SERIAL_TX == 4'hF)
        else $error("serial line not idle");
    a_read_drives_bus: assert property ($rose(rd) |-> ##1 DATA_OE)
        else $error("read did not drive the bus");
    a_bus_released: assert property (!rd |=> !DATA_OE)
        else $error("bus driven with no read");
    a_oe_has_cause: assert property ($rose(DATA_OE) |-> $past(rd))
        else $error("bus driven without a read start");
    a_read_data_hold: assert property (!$rose(rd) |=> $stable(DATA_OUT))
        else $error("read data moved without a read");
    a_irq_continuous: assert property (!BUS_STYLE_STROBE || IRQ_STYLE_SELECT
        |=> CHAN_IRQ_OE == 4'hF)
        else $error("interrupt pins not driven");
    a_tx_fill_cause: assert property ($rose(TX_VALID[2]) |-> $past(wr_c, 2))
        else $error("transmit data with no holding write");
    a_tx_head_hold: assert property (TX_VALID[2] && $past(TX_VALID[2])
        && !$past(TX_POP[2], 2) |-> $stable(TX_BYTE[23:16]))
        else $error("transmit head moved without a pop");

    c_read_start: cover property ($rose(rd));
    c_irq_rise: cover property ($rose(CHAN_IRQ[2]));
    c_tx_drained: cover property ($fell(TX_VALID[2]));
endmodule
`default_nettype wire

// [testbench/quh_top_tb_top.sv]
// self-checking bench for the quad host port
`include "quh_regs.svh"
`default_nettype none
module quh_top_tb_top
    import quh_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, style, rd_n, wr_n, cs_n, rnw, irq_sty, oe;
    logic [3:0] sel_n, irq, irq_oe, stx, rx_push, tx_pop, tx_valid;
    logic [1:0] chan_addr;
    logic [31:0] rx_byte, tx_byte;
    quh_reg_addr_t addr;
    quh_byte_t din, dout;
    int fail_count, n_compared, cyc;

    quh_top uut (.CLOCK(clk), .RESETN(rst_n), .BUS_STYLE_STROBE(style),
        .CHAN_A_SELECT_N(sel_n[0]), .CHAN_B_SELECT_N(sel_n[1]),
        .CHAN_C_SELECT_N(sel_n[2]), .CHAN_D_SELECT_N(sel_n[3]),
        .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .CHIP_SELECT_N(cs_n),
        .READ_NOT_WRITE(rnw), .CHAN_ADDR_LOW(chan_addr[0]), .CHAN_ADDR_HIGH(chan_addr[1]),
        .REG_ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
        .IRQ_STYLE_SELECT(irq_sty), .CHAN_IRQ(irq), .CHAN_IRQ_OE(irq_oe), .SERIAL_TX(stx),
        .RX_PUSH(rx_push), .RX_BYTE(rx_byte), .TX_POP(tx_pop), .TX_BYTE(tx_byte),
        .TX_VALID(tx_valid));
    quh_host_model host (.clk(clk), .strobe_style(style), .sel_n(sel_n), .rd_n(rd_n),
        .wr_n(wr_n), .cs_n(cs_n), .rnw(rnw), .chan_addr(chan_addr), .addr(addr),
        .din(din), .dout(dout));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int c, input quh_reg_addr_t a, input quh_byte_t d);
        quh_byte_t q;
        host.acc(1'b1, c, a, d, q);
    endtask
    task automatic rd(input int c, input quh_reg_addr_t a, input quh_byte_t e);
        quh_byte_t q;
        host.acc(1'b0, c, a, 8'h00, q);
        chk(q, e);
    endtask
    // interrupt pins follow their cause two edges later
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic push(input int c, input quh_byte_t v);
        @(posedge clk);
        #1;
        rx_push[c] = 1'b1;
        rx_byte[8*c+:8] = v;
        @(posedge clk);
        #1;
        rx_push = 4'h0;
        rx_byte = ~rx_byte;
        settle();
    endtask
    task automatic pop(input int c);
        @(posedge clk);
        #1;
        tx_pop[c] = 1'b1;
        @(posedge clk);
        #1;
        tx_pop = 4'h0;
        settle();
    endtask
    task automatic done(input string n);
        $display("test %s finished, mismatches so far %0d", n, fail_count);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("[FAIL] %0t cycle limit reached", $time);
            close_out();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        style = 1'b1;
        irq_sty = 1'b1;
        rx_push = 4'h0;
        rx_byte = 32'h0;
        tx_pop = 4'h0;
        repeat (20) @(posedge clk);
        #1;
        chk({4'h0, stx}, 8'h0F);
        chk({oe, irq, tx_valid[2:0]}, 8'h00);
        chk(dout, 8'h00);
        rst_n = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            rd(c, `QUH_REG_LCR, 8'h00);
            rd(c, `QUH_REG_ISR, `QUH_ISR_NONE);
            wr(c, `QUH_REG_LCR, 8'h80);
            rd(c, `QUH_REG_DATA, `QUH_DIV_LOW_RST);
            rd(c, `QUH_REG_IER, `QUH_DIV_HIGH_RST);
            wr(c, `QUH_REG_LCR, 8'h00);
        end
        done("reset values");
        for (int s = 1; s >= 0; s--)
        begin
            style = s[0];
            for (int c = 0; c < 4; c++)
                wr(c, `QUH_REG_SPR, 8'h30 + 8'(4 * s + c));
            for (int c = 0; c < 4; c++)
                rd(c, `QUH_REG_SPR, 8'h30 + 8'(4 * s + c));
        end
        style = 1'b1;
        wr(4, `QUH_REG_SPR, 8'hA5);
        style = 1'b0;
        for (int c = 0; c < 4; c++)
            rd(c, `QUH_REG_SPR, 8'hA5);
        style = 1'b1;
        done("channel select");
        wr(0, `QUH_REG_IER, 8'h01);
        settle();
        chk(irq[0], 1'b0);
        push(0, 8'h3C);
        chk(irq[0], 1'b1);
        rd(0, `QUH_REG_DATA, 8'h3C);
        settle();
        chk(irq[0], 1'b0);
        for (int f = 0; f < 2; f++)
        begin
            wr(0, `QUH_REG_ISR, 8'h41 | 8'(f << 3));
            for (int k = 0; k < 4; k++)
            begin
                chk(irq[0], 1'b0);
                push(0, 8'(k + 16 * f));
            end
            chk(irq[0], 1'b1);
            for (int k = 0; k < 4; k++)
                rd(0, `QUH_REG_DATA, 8'(k + 16 * f));
            settle();
            chk(irq[0], 1'b0);
        end
        done("receive interrupt");
        wr(1, `QUH_REG_IER, 8'h02);
        settle();
        chk(irq[1], 1'b1);
        wr(1, `QUH_REG_DATA, 8'h77);
        settle();
        chk(irq[1], 1'b0);
        chk(tx_byte[15:8], 8'h77);
        pop(1);
        chk(irq[1], 1'b1);
        wr(2, `QUH_REG_ISR, 8'h09);
        wr(2, `QUH_REG_IER, 8'h02);
        settle();
        chk(irq[2], 1'b1);
        // one byte more than fits, the last must be dropped
        for (int k = 0; k < 17; k++)
            wr(2, `QUH_REG_DATA, 8'(k));
        settle();
        for (int k = 0; k < 16; k++)
        begin
            chk(irq[2], (16 - k) < `QUH_TX_TRIG);
            chk(tx_byte[23:16], 8'(k));
            pop(2);
        end
        chk(tx_valid[2], 1'b0);
        chk(irq[2], 1'b1);
        done("transmit interrupt");
        irq_sty = 1'b0;
        wr(4, `QUH_REG_MCR, 8'h00);
        settle();
        chk(irq_oe, 4'h0);
        wr(4, `QUH_REG_MCR, 8'h08);
        settle();
        chk(irq_oe, 4'hF);
        done("interrupt style");
        // mid-run reset: a receive push held through it must leave no trace
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        rx_push = 4'h8;
        repeat (`QUH_RESET_MIN_CYC + 1) @(posedge clk);
        #1;
        chk({irq_oe, stx}, 8'h0F);
        rx_push = 4'h0;
        rst_n = 1'b1;
        rd(2, `QUH_REG_SPR, 8'h00);
        rd(3, `QUH_REG_LSR, (8'h01 << `QUH_LSR_TX_SPACE) | (8'h01 << `QUH_LSR_TX_EMPTY));
        done("mid-run reset");
        close_out();
    end
endmodule

bind quh_top quh_top_chk chk (.*);
`default_nettype wire
